// ### rtl/pbc_ctrl.sv
`timescale 1ns/10ps
// psram refresh, burst rom and card cycle controller (top)
module pbc_ctrl
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // refresh configuration
  input wire logic refresh_mode_select,
  input wire logic refresh_enable,
  input wire logic [2:0] refresh_clock_select,
  input wire logic [7:0] refresh_period_constant,
  input wire logic refresh_count_load,
  input wire logic [7:0] refresh_count_value,
  input wire logic [2:0] refresh_assert_cycles,
  input wire logic [1:0] precharge_cycles,
  input wire logic [2:0] memory_type_select,
  // area configuration
  input wire logic [1:0] area0_burst_beats,
  input wire logic [1:0] area5_burst_beats,
  input wire logic [1:0] area6_burst_beats,
  input wire logic [1:0] rom_bus_width,
  input wire logic area5_card_select,
  input wire logic area6_card_select,
  input wire logic [1:0] area5_bus_width,
  input wire logic [1:0] area6_bus_width,
  input wire logic [3:0] card_timing_reg,
  input wire logic [2:0] wait_control_two,
  // access request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  output logic req_done,
  // external bus pins
  input wire logic wait_n,
  output logic [EXT_W-1:0] ext_addr,
  output logic area0_select_n,
  output logic area5_select_n,
  output logic area5_upper_enable_n,
  output logic area6_select_n,
  output logic area6_upper_enable_n,
  output logic psram_ce_n,
  output logic output_enable_refresh_line_n,
  output logic rd_n,
  output logic wr_n,
  output logic card_io_cycle,
  output logic bus_is_16,
  // status
  output logic refresh_request,
  output logic self_refresh_active,
  output logic psram_blocked,
  output logic [7:0] refresh_timer_count
);
  pbc_tmr_if tmr ();
  logic wait_s;

  pbc_sync2 #(.W(1), .RST(PIN_NEG)) u_wait_sync (
    .clock(clock),
    .resetn(resetn),
    .d(wait_n),
    .q(wait_s)
  );

  pbc_refresh_timer u_timer (
    .clock(clock),
    .resetn(resetn),
    .bus(tmr)
  );

  // timer configuration straight from software bits
  assign tmr.cks = refresh_clock_select;
  assign tmr.period = refresh_period_constant;
  assign tmr.load = refresh_count_load;
  assign tmr.load_val = refresh_count_value;
  assign refresh_timer_count = tmr.count;

  // mode decode
  logic psram_mode, auto_ok, self_ok;
  assign psram_mode = memory_type_select == MEM_TYPE_PSRAM;
  assign auto_ok = psram_mode && refresh_enable && !refresh_mode_select;
  assign self_ok = psram_mode && refresh_enable && refresh_mode_select;

  // request decode
  logic [2:0] req_area;
  logic req_psram, card_area, req_card, req_io;
  logic [1:0] req_bst, req_w;
  logic [4:0] req_beats;
  logic [2:0] req_step;

  function automatic logic [4:0] beats_of(input logic [1:0] b,
                                          input logic [1:0] w);
    logic [1:0] e;
    e = b;
    if (w == WID_32 && b != BST_NONE) begin
      e = BST_4;
    end
    if (w == WID_16 && b == BST_16) begin
      e = BST_8;
    end
    case (e)
      BST_4: beats_of = BEATS_4;
      BST_8: beats_of = BEATS_8;
      BST_16: beats_of = BEATS_16;
      default: beats_of = BEATS_1;
    endcase
  endfunction

  // classify the incoming address
  always_comb begin
    req_area = req_addr[AREA_MSB:AREA_LSB];
    req_psram = psram_mode && req_area == AREA_PSRAM;
    card_area = (req_area == AREA_C5 && area5_card_select)
             || (req_area == AREA_C6 && area6_card_select);
    req_io = req_area == AREA_C6 && area6_card_select
          && req_addr >= IO_LO && req_addr <= IO_HI;
    req_card = card_area && (!req_addr[CARD_BIT] || req_io);
    if (req_area == AREA_ROM0) begin
      req_bst = area0_burst_beats;
    end else if (req_area == AREA_C5) begin
      req_bst = area5_burst_beats;
    end else if (req_area == AREA_C6) begin
      req_bst = area6_burst_beats;
    end else begin
      req_bst = BST_NONE;
    end
    // card width is 8 unless the field asks for 16
    if (req_card) begin
      req_w = ((req_area == AREA_C5 ? area5_bus_width : area6_bus_width)
               == WID_16) ? WID_16 : WID_8;
    end else begin
      req_w = rom_bus_width;
    end
    // page bursts on cards are read-only; io cycles never burst
    if (req_write || req_io || req_psram) begin
      req_beats = BEATS_1;
    end else begin
      req_beats = beats_of(req_bst, req_w);
    end
    case (req_w)
      WID_16: req_step = 3'h2;
      WID_32: req_step = 3'h4;
      default: req_step = 3'h1;
    endcase
  end

  // main sequencer state
  pbc_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [4:0] bcnt_q, bcnt_d;
  logic first_q, first_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [2:0] step_q, step_d;
  logic wr_q, wr_d, card_q, card_d, io_q, io_d;
  logic psr_q, psr_d, wide_q, wide_d, done_q, done_d;
  logic ref_start, hold_wait, beat_adv;
  logic [2:0] ws;
  logic [1:0] setup_c, hold_c;

  // refresh and self-refresh flags
  logic pend_q, pend_d, self_q, self_d;
  logic [1:0] xcnt_q, xcnt_d;
  logic blocked;

  assign ws = wait_control_two;
  assign setup_c = card_timing_reg[CT_SETUP_LSB +: 2];
  assign hold_c = card_timing_reg[CT_HOLD_LSB +: 2];
  // first beat samples the pin only with wait states
  assign hold_wait = (first_q ? (ws != 3'h0) : 1'b1) && !wait_s;
  assign beat_adv = state_q == ST_STROBE && cnt_q == 3'h0 && !hold_wait
                 && bcnt_q > BEATS_1;
  assign blocked = self_q || xcnt_q != 2'h0;

  // pending refresh and self-refresh next values
  always_comb begin
    pend_d = pend_q;
    self_d = self_q;
    xcnt_d = xcnt_q;
    if (ref_start) begin
      pend_d = 1'b0;
    end
    // a fresh match merges with one still waiting; set beats clear
    if (tmr.match && auto_ok) begin
      pend_d = 1'b1;
    end
    if (xcnt_q != 2'h0) begin
      xcnt_d = xcnt_q - 2'h1;
    end
    // entry only from idle so no psram cycle is cut short
    if (!self_q && self_ok && state_q == ST_IDLE && !pend_q) begin
      self_d = 1'b1;
    end else if (self_q && !refresh_mode_select) begin
      self_d = 1'b0;
      xcnt_d = precharge_cycles;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      self_q <= 1'b0;
      xcnt_q <= 2'h0;
    end else begin
      pend_q <= pend_d;
      self_q <= self_d;
      xcnt_q <= xcnt_d;
    end
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bcnt_d = bcnt_q;
    first_d = first_q;
    addr_d = addr_q;
    step_d = step_q;
    wr_d = wr_q;
    card_d = card_q;
    io_d = io_q;
    psr_d = psr_q;
    wide_d = wide_q;
    done_d = 1'b0;
    ref_start = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (pend_q && !self_q) begin
          ref_start = 1'b1;
          state_d = ST_REF_ON;
          cnt_d = (refresh_assert_cycles == 3'h0) ? 3'h0
                : refresh_assert_cycles - 3'h1;
        end else if (req_valid && !done_q
                     && !(req_psram && (blocked || self_ok))) begin
          addr_d = req_addr;
          wr_d = req_write;
          card_d = req_card;
          io_d = req_io;
          psr_d = req_psram;
          wide_d = req_w == WID_16;
          step_d = req_step;
          bcnt_d = req_beats;
          first_d = 1'b1;
          if (req_card && setup_c != 2'h0) begin
            state_d = ST_SETUP;
            cnt_d = {1'b0, setup_c} - 3'h1;
          end else begin
            state_d = ST_STROBE;
            cnt_d = ws;
          end
        end
      end
      ST_REF_ON: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else if (precharge_cycles != 2'h0) begin
          state_d = ST_REF_PC;
          cnt_d = {1'b0, precharge_cycles} - 3'h1;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_REF_PC: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_SETUP: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else begin
          state_d = ST_STROBE;
          cnt_d = ws;
        end
      end
      ST_STROBE: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else if (hold_wait) begin
          state_d = ST_STROBE;
        end else if (beat_adv) begin
          bcnt_d = bcnt_q - 5'h01;
          first_d = 1'b0;
          addr_d = addr_q + ADDR_W'(step_q);
          cnt_d = (ws == 3'h0) ? 3'h1 : ws;
        end else if (card_q && hold_c != 2'h0) begin
          state_d = ST_HOLD;
          cnt_d = {1'b0, hold_c} - 3'h1;
        end else begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      ST_HOLD: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      bcnt_q <= BEATS_1;
      first_q <= 1'b0;
      addr_q <= '0;
      step_q <= 3'h1;
      wr_q <= 1'b0;
      card_q <= 1'b0;
      io_q <= 1'b0;
      psr_q <= 1'b0;
      wide_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bcnt_q <= bcnt_d;
      first_q <= first_d;
      addr_q <= addr_d;
      step_q <= step_d;
      wr_q <= wr_d;
      card_q <= card_d;
      io_q <= io_d;
      psr_q <= psr_d;
      wide_q <= wide_d;
      done_q <= done_d;
    end
  end

  // pin values decoded from next state so pins line up with state_q
  logic [2:0] area_d;
  logic active_d, sel_d, strobe_d;
  logic [EXT_W-1:0] ea_q, ea_d;
  logic s0_q, s0_d, s5_q, s5_d, u5_q, u5_d, s6_q, s6_d, u6_q, u6_d;
  logic ce_q, ce_d, oer_q, oer_d, rd_q, rd_d, wrn_q, wrn_d;
  logic ioc_q, ioc_d, b16_q, b16_d, blk_q, blk_d;
  always_comb begin
    area_d = addr_d[AREA_MSB:AREA_LSB];
    active_d = state_d == ST_SETUP || state_d == ST_STROBE
            || state_d == ST_HOLD;
    strobe_d = state_d == ST_STROBE;
    sel_d = active_d && !psr_d;
    ea_d = addr_d[EXT_W-1:0];
    s0_d = !(sel_d && area_d == AREA_ROM0);
    s5_d = !(sel_d && area_d == AREA_C5);
    u5_d = !(sel_d && area_d == AREA_C5 && card_d && wide_d);
    s6_d = !(sel_d && area_d == AREA_C6);
    u6_d = !(sel_d && area_d == AREA_C6 && card_d && wide_d);
    ce_d = !(active_d && psr_d);
    // shared line: refresh pulse, self-refresh level, or psram read
    oer_d = !(state_d == ST_REF_ON || self_d
              || (strobe_d && psr_d && !wr_d));
    rd_d = !(strobe_d && !wr_d && !psr_d);
    wrn_d = !(strobe_d && wr_d);
    ioc_d = active_d && io_d;
    b16_d = active_d && wide_d;
    blk_d = self_d || xcnt_d != 2'h0;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ea_q <= '0;
      s0_q <= PIN_NEG;
      s5_q <= PIN_NEG;
      u5_q <= PIN_NEG;
      s6_q <= PIN_NEG;
      u6_q <= PIN_NEG;
      ce_q <= PIN_NEG;
      oer_q <= PIN_NEG;
      rd_q <= PIN_NEG;
      wrn_q <= PIN_NEG;
      ioc_q <= 1'b0;
      b16_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      ea_q <= ea_d;
      s0_q <= s0_d;
      s5_q <= s5_d;
      u5_q <= u5_d;
      s6_q <= s6_d;
      u6_q <= u6_d;
      ce_q <= ce_d;
      oer_q <= oer_d;
      rd_q <= rd_d;
      wrn_q <= wrn_d;
      ioc_q <= ioc_d;
      b16_q <= b16_d;
      blk_q <= blk_d;
    end
  end

  // ports come straight from flops
  assign ext_addr = ea_q;
  assign area0_select_n = s0_q;
  assign area5_select_n = s5_q;
  assign area5_upper_enable_n = u5_q;
  assign area6_select_n = s6_q;
  assign area6_upper_enable_n = u6_q;
  assign psram_ce_n = ce_q;
  assign output_enable_refresh_line_n = oer_q;
  assign rd_n = rd_q;
  assign wr_n = wrn_q;
  assign card_io_cycle = ioc_q;
  assign bus_is_16 = b16_q;
  assign req_done = done_q;
  assign refresh_request = pend_q;
  assign self_refresh_active = self_q;
  assign psram_blocked = blk_q;

  // checks on refresh, burst and card io sequencing
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence ref_begin;
    state_q == ST_IDLE ##1 state_q == ST_REF_ON;
  endsequence

  a_auto_cfg_only: assert property ($rose(pend_q) |-> $past(auto_ok))
    else $error("refresh request raised without auto-refresh setup");
  a_match_sets_pend: assert property (tmr.match && auto_ok |=> pend_q)
    else $error("timer match did not raise a refresh request");
  a_ref_line_low: assert property (ref_begin |-> !oer_q && ce_q)
    else $error("refresh line not asserted at refresh start");
  a_prech_ce_off: assert property (state_q == ST_REF_PC
      |-> ce_q && oer_q)
    else $error("chip enable or refresh line active in precharge");
  a_self_line_low: assert property (self_q |-> !oer_q)
    else $error("refresh line not low in self-refresh");
  a_self_no_access: assert property (self_q |-> ce_q)
    else $error("psram accessed in self-refresh");
  a_exit_blocks: assert property ($fell(self_q)
      && $past(precharge_cycles) != 2'h0 |-> blk_q && ce_q)
    else $error("psram not blocked after self-refresh exit");
  a_burst_sel_held: assert property (state_q == ST_STROBE && !first_q
      && !psr_q |-> !(s0_q && s5_q && s6_q))
    else $error("chip select released inside a burst");
  a_later_two: assert property (beat_adv
      |=> (state_q == ST_STROBE)[*2])
    else $error("later burst beat shorter than two cycles");
  a_first_no_wait: assert property (state_q == ST_STROBE && first_q
      && cnt_q == 3'h0 && ws == 3'h0 && bcnt_q == BEATS_1 && !card_q
      |=> state_q == ST_IDLE)
    else $error("first beat waited with no wait states set");
  a_io_in_area6: assert property (ioc_q |-> !s6_q)
    else $error("io card cycle outside area 6 select");
endmodule

// ### rtl/pbc_pkg.sv
// package: constants and types for the psram refresh, burst rom, card block
// Notes on behaviour
// - auto-refresh runs when mode select is 0 and refresh enable is 1
// - timer counts up from its current value once a clock is selected
// - count equal to period raises a request, clears count, keeps counting
// - refresh line held asserted for the programmed assert cycles
// - precharge cycles pass after refresh before chip enable returns
// - auto-refresh keeps running in normal, sleep and manual reset
// - mode select and enable both 1 hold the refresh line low
// - no psram access while self-refresh is active
// - clearing mode select ends self-refresh, then precharge cycles block access
// - self-refresh persists through normal, sleep, standby and manual reset
// - burst rom keeps chip select low and only steps the address
// - beats: 4/8/16 for 8-bit, 4/8 for 16-bit, 4 for 32-bit
// - wait sampled on first beat only with wait states, always later
// - with zero wait states later burst beats still take two cycles
// - card bits make area 5 memory card, area 6 memory and io card
// - memory card areas offer page-mode burst reads when enabled
// - card areas run 8 or 16 bits wide from their width field
// - lower 32 Mbyte of a card area runs memory card cycles
// - card timing sets setup and hold around the strobes
// - card cycles take software and pin waits like basic cycles
// - area 3 is psram when memory type field is 001
// - refresh waits for the running cycle; a newer request replaces it
// - area 6 addresses 1A000000 to 1BFFFFFF run io card cycles
package pbc_pkg;

  localparam int ADDR_W = 29;
  localparam int EXT_W = 26;
  localparam int AREA_MSB = 28;
  localparam int AREA_LSB = 26;
  localparam int CARD_BIT = 25;
  localparam int CT_SETUP_LSB = 0;
  localparam int CT_HOLD_LSB = 2;

  localparam logic [2:0] MEM_TYPE_PSRAM = 3'h1;
  localparam logic [2:0] AREA_ROM0 = 3'h0;
  localparam logic [2:0] AREA_PSRAM = 3'h3;
  localparam logic [2:0] AREA_C5 = 3'h5;
  localparam logic [2:0] AREA_C6 = 3'h6;
  localparam logic [ADDR_W-1:0] IO_LO = 29'h1A00_0000;
  localparam logic [ADDR_W-1:0] IO_HI = 29'h1BFF_FFFF;

  // burst field codes and bus width codes
  localparam logic [1:0] BST_NONE = 2'h0;
  localparam logic [1:0] BST_4 = 2'h1;
  localparam logic [1:0] BST_8 = 2'h2;
  localparam logic [1:0] BST_16 = 2'h3;
  localparam logic [1:0] WID_8 = 2'h1;
  localparam logic [1:0] WID_16 = 2'h2;
  localparam logic [1:0] WID_32 = 2'h3;
  localparam logic [4:0] BEATS_1 = 5'h01;
  localparam logic [4:0] BEATS_4 = 5'h04;
  localparam logic [4:0] BEATS_8 = 5'h08;
  localparam logic [4:0] BEATS_16 = 5'h10;

  // refresh clock select: 0 stops, others divide the bus clock
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [12:0] DIV_TAB [8] = '{13'h0001, 13'h0004, 13'h0010,
    13'h0040, 13'h0100, 13'h0400, 13'h0800, 13'h1000};

  // reset values
  localparam logic PIN_NEG = 1'b1;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [12:0] PRE_RST = 13'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REF_ON = 3'b001,
    ST_REF_PC = 3'b010,
    ST_SETUP = 3'b011,
    ST_STROBE = 3'b100,
    ST_HOLD = 3'b101
  } pbc_state_e;

endpackage

// ### rtl/pbc_tmr_if.sv
`timescale 1ns/10ps
// interface between the controller and its refresh timer
interface pbc_tmr_if;
  logic [2:0] cks;
  logic [7:0] period;
  logic load;
  logic [7:0] load_val;
  logic [7:0] count;
  logic match;
  modport timer (input cks, period, load, load_val, output count, match);
  modport ctrl (output cks, period, load, load_val, input count, match);
endinterface

// ### rtl/pbc_sync2.sv
`timescale 1ns/10ps
// two flip-flop synchroniser for pin inputs
module pbc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= RST;
      s2_q <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule

// ### rtl/pbc_refresh_timer.sv
`timescale 1ns/10ps
// refresh interval timer: prescaler, up counter and period compare
module pbc_refresh_timer
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // controller side
  pbc_tmr_if.timer bus
);
  logic [12:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  logic match_q, match_d;
  logic tick;

  // prescaler tick, then count or clear on compare
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    match_d = 1'b0;
    tick = 1'b0;
    if (bus.cks != CKS_STOP) begin
      if (pre_q >= DIV_TAB[bus.cks] - 13'h0001) begin
        pre_d = PRE_RST;
        tick = 1'b1;
      end else begin
        pre_d = pre_q + 13'h0001;
      end
    end else begin
      pre_d = PRE_RST;
    end
    // count resumes from whatever value it holds
    if (tick) begin
      if (cnt_q == bus.period) begin
        cnt_d = CNT_RST;
        match_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    // software load wins, it restarts the interval
    if (bus.load) begin
      cnt_d = bus.load_val;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pre_q <= PRE_RST;
      cnt_q <= CNT_RST;
      match_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      match_q <= match_d;
    end
  end

  assign bus.count = cnt_q;
  assign bus.match = match_q;
endmodule

// ### dv/pbc_mem_model.sv
// far-side memory model: rom, card or psram, stretched only on request
`timescale 1ns/10ps
module pbc_mem_model (
  // bench control: hold the wait pin asserted
  input logic stall,
  // wait pin towards the controller
  output logic wait_n
);
  // pulled up unless the bench asks for a stretch
  assign wait_n = !stall;
endmodule

// ### dv/pbc_ctrl_tb_top.sv
// bench top for the refresh, burst rom and card controller
`timescale 1ns/10ps
module pbc_ctrl_tb_top;
  import pbc_pkg::*;
  logic clock, resetn, refresh_mode_select, refresh_enable;
  logic refresh_count_load, req_valid, req_write, req_done, wait_n;
  logic [2:0] refresh_clock_select, refresh_assert_cycles;
  logic [2:0] memory_type_select, wait_control_two;
  logic [7:0] refresh_period_constant, refresh_count_value;
  logic [7:0] refresh_timer_count;
  logic [1:0] precharge_cycles, area0_burst_beats, area5_burst_beats;
  logic [1:0] area6_burst_beats, rom_bus_width;
  logic [1:0] area5_bus_width, area6_bus_width;
  logic area5_card_select, area6_card_select;
  logic [3:0] card_timing_reg;
  logic [ADDR_W-1:0] req_addr, ad;
  logic [EXT_W-1:0] ext_addr;
  logic area0_select_n, area5_select_n, area5_upper_enable_n;
  logic area6_select_n, area6_upper_enable_n, psram_ce_n, rd_n, wr_n;
  logic output_enable_refresh_line_n, card_io_cycle, bus_is_16;
  logic refresh_request, self_refresh_active, psram_blocked;
  logic [2:0] ar;
  logic seen_io, seen16, broke, stall, w16;
  logic [3:0] pins;
  int bad_count, comparisons, seed, n, k, ws, per;

  // device under test and far side
  pbc_ctrl i_dut (.*);
  pbc_mem_model i_mem (.stall(stall), .wait_n(wait_n));

  // bus clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one access, timed in cycles; flags a select that lifts mid-burst
  task automatic run(input logic [ADDR_W-1:0] a);
    logic low;
    @(negedge clock);
    req_addr = a;
    req_valid = 1'b1;
    n = 0;
    low = 1'b0;
    broke = 1'b0;
    seen_io = 1'b0;
    seen16 = 1'b0;
    pins = '0;
    do begin
      @(negedge clock);
      n++;
      seen_io |= card_io_cycle;
      seen16 |= bus_is_16;
      pins |= {!rd_n, !wr_n, !area5_upper_enable_n, !area6_upper_enable_n};
      k = area0_select_n & area5_select_n & area6_select_n;
      if (!req_done && low && k) broke = 1'b1;
      low |= !k;
    end while (!req_done && n < 500);
    req_valid = 1'b0;
  endtask

  // beats actually run, after clamping by rom width
  function automatic int beats(input logic [1:0] b, input logic [1:0] w);
    if (b == BST_NONE) return 1;
    if (b == BST_4 || w == WID_32) return 4;
    if (b == BST_8 || w == WID_16) return 8;
    return 16;
  endfunction

  // hang guard, about twice the 22k cycles the run needs
  initial begin
    #200us;
    bad_count++;
    close_out();
  end

  // main sequence
  initial begin
    seed = 32'hca38_8a74;
    {refresh_mode_select, refresh_enable, refresh_clock_select,
     refresh_period_constant, refresh_count_load, refresh_count_value,
     refresh_assert_cycles, precharge_cycles, memory_type_select,
     area0_burst_beats, area5_burst_beats, area6_burst_beats,
     rom_bus_width, area5_card_select, area6_card_select, area5_bus_width,
     area6_bus_width, card_timing_reg, wait_control_two, req_valid,
     req_write, req_addr, stall} = '0;
    resetn = 1'b0;
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    chk({area0_select_n, area5_select_n, area6_select_n, psram_ce_n,
         output_enable_refresh_line_n, rd_n, wr_n, req_done},
        32'h0000_00fe);
    // burst reads: every beat code against every rom width
    for (int i = 0; i < 12; i++) begin
      {area0_burst_beats, area5_burst_beats, area6_burst_beats} = {3{2'(i)}};
      rom_bus_width = 2'(1 + i / 4);
      wait_control_two = 3'($random(seed)) & 3'h3;
      ws = wait_control_two;
      ar = (i % 3 == 0) ? AREA_ROM0 : (i % 3 == 1) ? AREA_C5 : AREA_C6;
      run({ar, 26'h0000_0100});
      k = beats(2'(i), rom_bus_width);
      chk(n, 2 + ws + (k - 1) * ((ws > 0 ? ws : 1) + 1));
      chk(broke, 0);
      chk(ext_addr, 32'h0000_0100
          + (k - 1) * (2 ** (rom_bus_width - 1)));
      chk(pins, 4'h8);
    end
    // card cycles: memory and io, random timing and width
    {area0_burst_beats, area5_burst_beats, area6_burst_beats} = '0;
    // pin wait: ignored on an unwaited first beat, honoured otherwise
    stall = 1'b1;
    wait_control_two = 3'h0;
    repeat (3) @(negedge clock);
    run({AREA_ROM0, 26'h0000_0200});
    chk(n, 2);
    wait_control_two = 3'h1;
    fork
      run({AREA_ROM0, 26'h0000_0200});
      begin
        repeat (10) @(negedge clock);
        stall = 1'b0;
      end
    join
    chk(n, 12);
    // no psram refresh runs beside the area 5 and 6 cards here
    {area5_card_select, area6_card_select} = 2'h3;
    for (int i = 0; i < 8; i++) begin
      card_timing_reg = 4'($random(seed));
      wait_control_two = 3'($random(seed)) & 3'h3;
      ws = wait_control_two;
      {area5_bus_width, area6_bus_width} = 4'($random(seed));
      {area5_burst_beats, area6_burst_beats} = 4'($random(seed));
      req_write = 1'($random(seed));
      ar = (i % 4 == 2) ? AREA_C5 : AREA_C6;
      ad = (i % 4 == 0) ? IO_LO : (i % 4 == 1) ? (IO_HI & ~29'h0000_0003)
           : {ar, 26'h0000_0040};
      w16 = (ar == AREA_C5 ? area5_bus_width : area6_bus_width) == WID_16;
      run(ad);
      k = (req_write || i % 4 < 2) ? 1 : beats(ar == AREA_C5
          ? area5_burst_beats : area6_burst_beats, w16 ? WID_16 : WID_8);
      chk(n, 2 + ws + card_timing_reg[1:0] + card_timing_reg[3:2]
          + (k - 1) * ((ws > 0 ? ws : 1) + 1));
      chk(seen_io, i % 4 < 2);
      chk(seen16, w16);
      chk(pins, {!req_write, req_write, w16 && ar == AREA_C5,
          w16 && ar == AREA_C6});
    end
    // auto-refresh from a loaded count, then from zero
    repeat (20000) @(negedge clock);
    memory_type_select = MEM_TYPE_PSRAM;
    per = 4 + ($unsigned($random(seed)) % 16);
    refresh_period_constant = 8'(per);
    refresh_count_value = 8'($unsigned($random(seed)) % per);
    refresh_assert_cycles = 3'($random(seed));
    precharge_cycles = 2'($random(seed));
    refresh_count_load = 1'b1;
    refresh_enable = 1'b1;
    @(negedge clock);
    refresh_count_load = 1'b0;
    repeat (3) @(negedge clock);
    chk(refresh_timer_count, refresh_count_value);
    refresh_clock_select = 3'h1;
    for (int r = 0; r < 8; r++) begin
      k = 4 * (per - (r == 0 ? refresh_count_value : 0));
      n = 0;
      while (!refresh_request && n < 1000) begin
        @(negedge clock);
        n++;
      end
      chk(n >= k - 16 && n <= k + 6, 1);
      n = 0;
      while (output_enable_refresh_line_n && n < 20) begin
        @(negedge clock);
        n++;
      end
      n = 0;
      while (!output_enable_refresh_line_n && n < 20) begin
        @(negedge clock);
        n++;
      end
      chk(n, refresh_assert_cycles == 0 ? 1 : refresh_assert_cycles);
    end
    // self-refresh holds off psram, exit blocks for precharge
    refresh_clock_select = CKS_STOP;
    refresh_mode_select = 1'b1;
    repeat (5) @(negedge clock);
    chk(output_enable_refresh_line_n, 0);
    chk(self_refresh_active, 1);
    chk(psram_blocked, 1);
    req_addr = {AREA_PSRAM, 26'h0000_0010};
    req_valid = 1'b1;
    n = 0;
    repeat (30) @(negedge clock) n += req_done | !psram_ce_n;
    chk(n, 0);
    refresh_mode_select = 1'b0;
    n = 0;
    while (!req_done && n < 50) begin
      @(negedge clock);
      n++;
    end
    req_valid = 1'b0;
    chk(n, precharge_cycles + wait_control_two + 3);
    close_out();
  end
endmodule
